// [pkg/txenc_pkg.sv]
/*
 * constants and types for the transmit system-input line encoder.
 * assumes one channel per instance; the framer clocks data on the line clock.
 */
// Summary of operation
// - single rail: serial data on positive rail
// - single rail: B3ZS for DS3/STS-1, HDB3 for E3
// - dual rail: positive rail requests positive pulse
// - dual rail: no encoding, pulses forwarded unchanged
// - dual rail: negative rail requests negative pulse
// - single rail: negative rail ignored, tied low
// - pulses leave on differential output pair
// - plus above minus positive; reverse negative
// - outputs high impedance when transmitter off
package txenc_pkg;

	localparam int unsigned SYNC_STAGES = 2;
	localparam int unsigned ENC_DEPTH   = 4;
	localparam int unsigned B3ZS_RUN    = 3;
	localparam int unsigned HDB3_RUN    = 4;

	localparam logic RST_DUAL_RAIL = 1'h0;
	localparam logic RST_E3_MODE   = 1'h0;
	localparam logic RST_TX_ALLOW  = 1'h0;
	localparam logic RST_LAST_POL  = 1'h0;

	// line clock rates in kHz, for reference by the bench
	localparam int unsigned STS1_RATE_KHZ = 51840;
	localparam int unsigned DS3_RATE_KHZ  = 44736;
	localparam int unsigned E3_RATE_KHZ   = 34368;

	typedef enum logic [1:0] {
		SYM_ZERO = 2'h0,
		SYM_MARK = 2'h1,
		SYM_VIOL = 2'h2,
		SYM_BSUB = 2'h3
	} txenc_sym_type;

endpackage : txenc_pkg

// [pkg/txenc_pulse_if.sv]
/*
 * interface between the link-side logic and the line encoder.
 * assumes both ends run on the line clock.
 */
`timescale 1ns/1ps
interface txenc_pulse_if;
	logic enable;
	logic hdb3_sel;
	logic data;
	logic pulse_pos;
	logic pulse_neg;

	modport enc (input enable, input hdb3_sel, input data, output pulse_pos, output pulse_neg);
	modport ctl (output enable, output hdb3_sel, output data, input pulse_pos, input pulse_neg);
endinterface : txenc_pulse_if

// [hdl/txenc_encoder.sv]
/*
 * B3ZS / HDB3 encoder for single-rail data, fixed pipeline of four symbols.
 * assumes clock is the line clock and reset is already synchronised to it.
 */
`timescale 1ns/1ps
module txenc_encoder
	import txenc_pkg::*;
(
	input wire logic    clock,
	input wire logic    reset,
	txenc_pulse_if.enc  link
);

	txenc_sym_type sym_r   [ENC_DEPTH];
	txenc_sym_type sym_nxt [ENC_DEPTH];
	logic          parity_r;
	logic          parity_nxt;
	logic          last_pol_r;
	logic          pos_r;
	logic          neg_r;

	////////////////////////////////////////////////////////////////////////////
	// zero-run detection and symbol tap
	wire hdb3      = link.hdb3_sel;
	wire head_zero = (sym_r[0] == SYM_ZERO) && (sym_r[1] == SYM_ZERO);
	wire zero_run  = !link.data && head_zero && (!hdb3 || (sym_r[2] == SYM_ZERO));
	wire odd_marks = parity_r;
	txenc_sym_type tap;
	assign tap = hdb3 ? sym_r[HDB3_RUN - 1] : sym_r[B3ZS_RUN - 1];
	wire tap_pulse = (tap != SYM_ZERO);
	wire tap_alt   = (tap == SYM_MARK) || (tap == SYM_BSUB);
	// violation repeats last polarity, marks alternate
	wire tap_pol   = tap_alt ? !last_pol_r : last_pol_r;

	always_comb begin
		sym_nxt[0] = link.data ? SYM_MARK : SYM_ZERO;
		for (int k = 1; k < ENC_DEPTH; k++) begin
			sym_nxt[k] = sym_r[k - 1];
		end
		parity_nxt = parity_r ^ link.data;
		if (zero_run) begin
			// odd marks since last violation: 00V / 000V, else B0V / B00V
			sym_nxt[0] = SYM_VIOL;
			if (!odd_marks) begin
				if (hdb3) begin
					sym_nxt[HDB3_RUN - 1] = SYM_BSUB;
				end else begin
					sym_nxt[B3ZS_RUN - 1] = SYM_BSUB;
				end
			end
			parity_nxt = 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pipeline and polarity state; cleared while the channel is off
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			for (int k = 0; k < ENC_DEPTH; k++) sym_r[k] <= SYM_ZERO;
			parity_r   <= 1'h0;
			last_pol_r <= RST_LAST_POL;
			pos_r      <= 1'h0;
			neg_r      <= 1'h0;
		end else if (!link.enable) begin
			for (int k = 0; k < ENC_DEPTH; k++) sym_r[k] <= SYM_ZERO;
			parity_r   <= 1'h0;
			last_pol_r <= RST_LAST_POL;
			pos_r      <= 1'h0;
			neg_r      <= 1'h0;
		end else begin
			sym_r      <= sym_nxt;
			parity_r   <= parity_nxt;
			last_pol_r <= tap_pulse ? tap_pol : last_pol_r;
			pos_r      <= tap_pulse && tap_pol;
			neg_r      <= tap_pulse && !tap_pol;
		end
	end

	assign link.pulse_pos = pos_r;
	assign link.pulse_neg = neg_r;

endmodule : txenc_encoder

// [hdl/txenc_top.sv]
/*
 * transmit system-input stage of one channel: rail sampling, line coding,
 * differential driver with tri-state control.
 * assumes the framer drives the rails from the line clock it also supplies,
 * and that configuration inputs are static levels on the system clock.
 */
`timescale 1ns/1ps
module txenc_top
	import txenc_pkg::*;
(
	input  wire logic clock,
	input  wire logic reset,
	input  wire logic tx_line_clock,
	input  wire logic tx_positive_rail_in,
	input  wire logic tx_negative_rail_in,
	input  wire logic transmitter_power_on,
	input  wire logic tx_on_ctrl,
	input  wire logic cfg_dual_rail,
	input  wire logic cfg_e3_mode,
	output logic      line_out_plus,
	output logic      line_out_plus_oe,
	output logic      line_out_minus,
	output logic      line_out_minus_oe,
	output logic      tx_active_status,
	output logic      dual_rail_status
);

	////////////////////////////////////////////////////////////////////////////
	// shared helpers
	// one step of a synchroniser chain, newest bit at the bottom
	function automatic logic [SYNC_STAGES-1:0] sync_step(
		input logic [SYNC_STAGES-1:0] chain,
		input logic                   din
	);
		return {chain[SYNC_STAGES-2:0], din};
	endfunction : sync_step

	// a pulse request only reaches the pins while the link side is enabled
	function automatic logic gate_pulse(
		input logic on,
		input logic req
	);
		return on && req;
	endfunction : gate_pulse

	// driver enable lives in the link domain, read back through active_sync_r
	logic drive_en_r;

	////////////////////////////////////////////////////////////////////////////
	// system domain: pin synchroniser and power sequencing
	typedef enum logic [3:0] {
		PWR_OFF   = 4'h1,
		PWR_ARM   = 4'h2,
		PWR_ON    = 4'h4,
		PWR_DRAIN = 4'h8
	} txenc_pwr_type;

	txenc_pwr_type          pwr_state_r;
	txenc_pwr_type          pwr_state_nxt;
	logic [SYNC_STAGES-1:0] pwr_sync_r;
	logic [SYNC_STAGES-1:0] active_sync_r;
	logic                   tx_allow_r;
	logic                   tx_allow_nxt;
	logic                   dual_rail_r;
	logic                   e3_mode_r;
	logic                   tx_active_r;

	wire pwr_on     = pwr_sync_r[SYNC_STAGES-1];
	wire link_busy  = active_sync_r[SYNC_STAGES-1];
	wire allow_req  = pwr_on && tx_on_ctrl;
	// mode follows config only while fully off, and is frozen a cycle
	// before the enable rises so the link never sees a half-changed mode
	wire mode_load  = (pwr_state_r == PWR_OFF);

	always_comb begin
		pwr_state_nxt = pwr_state_r;
		unique case (pwr_state_r)
			PWR_OFF: begin
				if (allow_req) begin
					pwr_state_nxt = PWR_ARM;
				end
			end
			PWR_ARM: begin
				pwr_state_nxt = allow_req ? PWR_ON : PWR_OFF;
			end
			PWR_ON: begin
				if (!allow_req) begin
					pwr_state_nxt = PWR_DRAIN;
				end
			end
			PWR_DRAIN: begin
				// line side must confirm off before the mode may move
				if (!link_busy) begin
					pwr_state_nxt = PWR_OFF;
				end
			end
			default: begin
				pwr_state_nxt = PWR_OFF;
			end
		endcase
	end

	assign tx_allow_nxt = (pwr_state_nxt == PWR_ON);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pwr_sync_r    <= '0;
			active_sync_r <= '0;
		end else begin
			pwr_sync_r    <= sync_step(pwr_sync_r, transmitter_power_on);
			active_sync_r <= sync_step(active_sync_r, drive_en_r);
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pwr_state_r <= PWR_OFF;
			tx_allow_r  <= RST_TX_ALLOW;
		end else begin
			pwr_state_r <= pwr_state_nxt;
			tx_allow_r  <= tx_allow_nxt;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			dual_rail_r <= RST_DUAL_RAIL;
			e3_mode_r   <= RST_E3_MODE;
		end else if (mode_load) begin
			dual_rail_r <= cfg_dual_rail;
			e3_mode_r   <= cfg_e3_mode;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			tx_active_r <= 1'h0;
		end else begin
			tx_active_r <= link_busy;
		end
	end

	assign tx_active_status = tx_active_r;
	assign dual_rail_status = dual_rail_r;

	////////////////////////////////////////////////////////////////////////////
	// link domain: reset release, control synchronisers
	logic [SYNC_STAGES-1:0] link_rst_r;
	logic [SYNC_STAGES-1:0] allow_sync_r;
	logic [SYNC_STAGES-1:0] dual_sync_r;
	logic [SYNC_STAGES-1:0] e3_sync_r;

	wire link_rst  = link_rst_r[SYNC_STAGES-1];
	wire link_on   = allow_sync_r[SYNC_STAGES-1];
	// quasi-static: mode bits only change while link_on is low
	wire link_dual = dual_sync_r[SYNC_STAGES-1];
	wire link_e3   = e3_sync_r[SYNC_STAGES-1];

	always_ff @(posedge tx_line_clock or posedge reset) begin
		if (reset) begin
			link_rst_r <= '1;
		end else begin
			link_rst_r <= sync_step(link_rst_r, 1'h0);
		end
	end

	always_ff @(posedge tx_line_clock or posedge link_rst) begin
		if (link_rst) begin
			allow_sync_r <= '0;
			dual_sync_r  <= '0;
			e3_sync_r    <= '0;
		end else begin
			allow_sync_r <= sync_step(allow_sync_r, tx_allow_r);
			dual_sync_r  <= sync_step(dual_sync_r, dual_rail_r);
			e3_sync_r    <= sync_step(e3_sync_r, e3_mode_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// link domain: rail sampling, one bit per rising line clock edge
	logic pos_smp_r;
	logic neg_smp_r;

	always_ff @(posedge tx_line_clock or posedge link_rst) begin
		if (link_rst) begin
			pos_smp_r <= 1'h0;
			neg_smp_r <= 1'h0;
		end else begin
			pos_smp_r <= tx_positive_rail_in;
			// negative rail dropped outright in single rail
			neg_smp_r <= link_dual && tx_negative_rail_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// link domain: encoder for single rail
	txenc_pulse_if enc_if ();

	assign enc_if.enable   = link_on && !link_dual;
	assign enc_if.hdb3_sel = link_e3;
	assign enc_if.data     = pos_smp_r;

	txenc_encoder u_encoder (
		.clock (tx_line_clock),
		.reset (link_rst),
		.link  (enc_if.enc)
	);

	////////////////////////////////////////////////////////////////////////////
	// link domain: driver; dual rail bypasses the coder untouched
	// both rails requested together in dual rail drives both high: no swing
	wire pulse_pos = link_dual ? pos_smp_r : enc_if.pulse_pos;
	wire pulse_neg = link_dual ? neg_smp_r : enc_if.pulse_neg;

	logic plus_r;
	logic minus_r;

	always_ff @(posedge tx_line_clock or posedge link_rst) begin
		if (link_rst) begin
			drive_en_r <= 1'h0;
			plus_r     <= 1'h0;
			minus_r    <= 1'h0;
		end else begin
			drive_en_r <= link_on;
			plus_r     <= gate_pulse(link_on, pulse_pos);
			minus_r    <= gate_pulse(link_on, pulse_neg);
		end
	end

	assign line_out_plus     = plus_r;
	assign line_out_minus    = minus_r;
	assign line_out_plus_oe  = drive_en_r;
	assign line_out_minus_oe = drive_en_r;

endmodule : txenc_top

// [verif/txenc_framer_model.sv]
/* framer model: free-running line clock, rails replay two 16-bit patterns.
 * assumes the bench holds patterns steady while the transmitter is on. */
`timescale 1ns/1ps
module txenc_framer_model (
	output logic             tx_line_clock,
	output logic             pos,
	output logic             neg,
	input  wire logic [15:0] pat_pos,
	input  wire logic [15:0] pat_neg
);
	logic [3:0] idx_r = 4'h0;
	initial begin
		tx_line_clock = 1'h0;
		#7;
		forever #32 tx_line_clock = ~tx_line_clock; // 64 ns, free running
	end
	// one bit per rising edge; dual patterns come pre-coded by the bench
	// neg replays pat_neg in both modes; the single rail tests set it all ones to prove it ignored
	always @(posedge tx_line_clock) begin
		idx_r <= idx_r + 4'h1;
		pos <= pat_pos[idx_r];
		neg <= pat_neg[idx_r];
	end
endmodule : txenc_framer_model

// [verif/txenc_top_properties.sv]
/* port checker for txenc_top.
 * assumes mode only changes while the transmitter is off. */
`timescale 1ns/1ps
module txenc_top_properties
	import txenc_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic tx_line_clock,
	input wire logic tx_positive_rail_in,
	input wire logic tx_negative_rail_in,
	input wire logic transmitter_power_on,
	input wire logic tx_on_ctrl,
	input wire logic cfg_dual_rail,
	input wire logic cfg_e3_mode,
	input wire logic line_out_plus,
	input wire logic line_out_plus_oe,
	input wire logic line_out_minus,
	input wire logic line_out_minus_oe,
	input wire logic tx_active_status,
	input wire logic dual_rail_status
);
	////////////////////////////////////////////////////////////
	logic last_pol_r, have_r, last_v_r, vseen_r;
	wire  pulse = line_out_plus | line_out_minus;
	wire  same  = pulse & have_r & (line_out_plus == last_pol_r);
	// cleared when off, as the encoder state is
	always_ff @(posedge tx_line_clock or posedge reset) begin
		if (reset) begin
			{last_pol_r, have_r, last_v_r, vseen_r} <= 4'h0;
		end else if (!line_out_plus_oe) begin
			{last_pol_r, have_r, last_v_r, vseen_r} <= 4'h0;
		end else if (pulse) begin
			last_pol_r <= line_out_plus;
			have_r <= 1'h1;
			last_v_r <= same ? line_out_plus : last_v_r;
			vseen_r <= vseen_r | same;
		end
	end
	////////////////////////////////////////////////////////////
	chk_dual_plus: assert property (@(posedge tx_line_clock) disable iff (reset)
		dual_rail_status && line_out_plus_oe && $past(line_out_plus_oe, 3) |-> line_out_plus == $past(tx_positive_rail_in, 2))
		else $error("plus differs from sampled positive rail");
	chk_dual_minus: assert property (@(posedge tx_line_clock) disable iff (reset)
		dual_rail_status && line_out_minus_oe && $past(line_out_minus_oe, 3) |-> line_out_minus == $past(tx_negative_rail_in, 2))
		else $error("minus differs from sampled negative rail");
	chk_tri_quiet: assert property (@(posedge tx_line_clock) disable iff (reset)
		!line_out_plus_oe |-> !line_out_plus && !line_out_minus) else $error("pulse while tri-stated");
	chk_oe_pair: assert property (@(posedge tx_line_clock) disable iff (reset)
		line_out_plus_oe == line_out_minus_oe) else $error("pair enables differ");
	chk_single_diff: assert property (@(posedge tx_line_clock) disable iff (reset)
		!dual_rail_status && line_out_plus_oe |-> !(line_out_plus && line_out_minus)) else $error("both pulses in single rail");
	chk_off_fast: assert property (@(posedge tx_line_clock) disable iff (reset)
		$fell(tx_on_ctrl) |-> ##[1:8] !line_out_plus_oe) else $error("driver not off in time");
	chk_mode_hold: assert property (@(posedge clock) disable iff (reset)
		tx_active_status && $past(tx_active_status) |-> $stable(dual_rail_status)) else $error("mode moved while on");
	chk_viol_alt: assert property (@(posedge tx_line_clock) disable iff (reset)
		!dual_rail_status && same && vseen_r |-> line_out_plus != last_v_r) else $error("violations not alternating");
endmodule : txenc_top_properties

bind txenc_top txenc_top_properties chk (.clock(clock), .reset(reset), .tx_line_clock(tx_line_clock),
	.tx_positive_rail_in(tx_positive_rail_in), .tx_negative_rail_in(tx_negative_rail_in),
	.transmitter_power_on(transmitter_power_on), .tx_on_ctrl(tx_on_ctrl), .cfg_dual_rail(cfg_dual_rail),
	.cfg_e3_mode(cfg_e3_mode), .line_out_plus(line_out_plus), .line_out_plus_oe(line_out_plus_oe),
	.line_out_minus(line_out_minus), .line_out_minus_oe(line_out_minus_oe),
	.tx_active_status(tx_active_status), .dual_rail_status(dual_rail_status));

// [verif/tb_tx_system_input_line_encoder.sv]
/* self-checking bench for txenc_top with the framer model.
 * assumes pulse counts over whole pattern periods are latency-free. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR %s expected %0d seen %0d", nm, e, g); end end
module tb_tx_system_input_line_encoder;
	import txenc_pkg::*;
	logic        clock, reset, lclk, pos, neg, pin_on, ctrl_on, dual, e3;
	logic        plus, plus_oe, minus, minus_oe, active, dual_st;
	logic [15:0] pat_pos, pat_neg;
	int          n_mismatch, n_compared, cycles, p, m;
	txenc_framer_model fm (.tx_line_clock(lclk), .pos(pos), .neg(neg), .pat_pos(pat_pos), .pat_neg(pat_neg));
	txenc_top uut (.clock(clock), .reset(reset), .tx_line_clock(lclk), .tx_positive_rail_in(pos),
		.tx_negative_rail_in(neg), .transmitter_power_on(pin_on), .tx_on_ctrl(ctrl_on), .cfg_dual_rail(dual),
		.cfg_e3_mode(e3), .line_out_plus(plus), .line_out_plus_oe(plus_oe), .line_out_minus(minus),
		.line_out_minus_oe(minus_oe), .tx_active_status(active), .dual_rail_status(dual_st));
	////////////////////////////////////////////////////////////
	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	task power(input logic pn, input logic cn);
		@(posedge clock);
		pin_on <= pn;
		ctrl_on <= cn;
		for (int i = 0; i < 20 && plus_oe !== (pn & cn); i++) @(posedge lclk);
		repeat (6) @(posedge clock);
		`CHK("oe plus", pn & cn, plus_oe)
		`CHK("oe minus", pn & cn, minus_oe)
		`CHK("active", pn & cn, active)
	endtask : power
	task setup(input logic d, input logic e, input logic [15:0] pp, input logic [15:0] pn);
		power(1'h0, 1'h0);
		@(posedge clock);
		dual <= d;
		e3 <= e;
		pat_pos <= pp;
		pat_neg <= pn;
		power(1'h1, 1'h1);
	endtask : setup
	task measure(input int n);
		p = 0;
		m = 0;
		repeat (12) @(posedge lclk);
		repeat (n) begin
			@(negedge lclk);
			p += plus;
			m += minus;
		end
	endtask : measure
	////////////////////////////////////////////////////////////
	task t_dual;
		setup(1'h1, 1'h0, 16'h1234, 16'h0480);
		measure(32);
		`CHK("dual plus", 2 * $countones(pat_pos), p)
		`CHK("dual minus", 2 * $countones(pat_neg), m)
		@(posedge clock);
		dual <= 1'h0;
		repeat (8) @(posedge clock);
		`CHK("mode held", 1'h1, dual_st)
	endtask : t_dual
	task t_ones;
		setup(1'h0, 1'h0, 16'hffff, 16'hffff);
		measure(32);
		`CHK("ones plus", 16, p)
		`CHK("ones minus", 16, m)
		`CHK("single mode", 1'h0, dual_st)
	endtask : t_ones
	task t_zeros(input logic e);
		setup(1'h0, e, 16'h0000, 16'hffff);
		measure(48);
		`CHK("zero plus", 48 / (e ? HDB3_RUN : B3ZS_RUN), p)
		`CHK("zero minus", 48 / (e ? HDB3_RUN : B3ZS_RUN), m)
	endtask : t_zeros
	task t_off;
		power(1'h1, 1'h0);
		`CHK("plus off", 1'h0, plus)
		power(1'h1, 1'h1);
		power(1'h0, 1'h1);
		`CHK("minus off", 1'h0, minus)
	endtask : t_off
	////////////////////////////////////////////////////////////
	initial begin
		clock = 1'h0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	initial begin
		{reset, pin_on, ctrl_on, dual, e3} = 5'h10;
		{pat_pos, pat_neg} = 32'h0;
		repeat (5) @(posedge clock);
		reset <= 1'h0;
		t_dual();
		t_ones();
		t_zeros(1'h0);
		t_zeros(1'h1);
		t_off();
		end_of_test();
	end
endmodule : tb_tx_system_input_line_encoder
